// ==== logic/pso_timing.sv ====
// Word divider and reset re-timing for the serializer
`timescale 1ns/1ps
`default_nettype none
module pso_timing
   import pso_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic reset_n,
   input  wire logic async_reset_in,
   pso_tick_if.gen   tick
);
   pso_rst_t   state_reg;  // Release sequence
   pso_rst_t   state_next;
   logic [3:0] idx_reg;    // Bit counter, the divider
   logic [3:0] idx_next;
   logic       last_bit;

   // >= guards against a width change mid-word
   assign last_bit = (idx_reg >= tick.data_width - 4'h1);
   assign idx_next = last_bit ? 4'h0 : idx_reg + 4'h1;

   // Divided side released first, fast side on next fast edge
   always_comb begin
      case (state_reg)
         PSO_RS_HOLD: state_next = PSO_RS_DIV;
         PSO_RS_DIV:  state_next = tick.fast_tick ? PSO_RS_RUN : PSO_RS_DIV;
         PSO_RS_RUN:  state_next = PSO_RS_RUN;
         default:     state_next = PSO_RS_HOLD;
      endcase
      if (async_reset_in) begin
         state_next = PSO_RS_HOLD;
      end
   end

   // Counter restarts at release, so all copies leave reset in step
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         state_reg <= PSO_RS_HOLD;
         idx_reg   <= 4'h0;
      end else begin
         state_reg <= state_next;
         idx_reg   <= (state_reg == PSO_RS_HOLD || async_reset_in) ? 4'h0 : idx_next;
      end
   end

   // Two re-timed resets, one per domain
   assign tick.hard_clear   = async_reset_in;
   assign tick.div_rst      = (state_reg == PSO_RS_HOLD);
   assign tick.fast_rst     = (state_reg != PSO_RS_RUN);
   assign tick.div_tick     = (state_reg != PSO_RS_HOLD) && last_bit && !async_reset_in;
   // DDR: fast clock runs at half the bit rate, both edges used
   assign tick.fast_tick    = !tick.data_ddr || !idx_reg[0];
   assign tick.bit_idx      = idx_reg;
   assign tick.bit_idx_next = (state_reg == PSO_RS_HOLD) ? 4'h0 : idx_next;

   chk_release_order: assert property (@(posedge clk_sys) disable iff (!reset_n)
      $fell(tick.fast_rst) |-> !$past(tick.div_rst)) else $error("fast reset left before divided");
endmodule
`default_nettype wire

// ==== logic/pso_top.sv ====
// Output serializer top: bus slave, configuration and data path
`timescale 1ns/1ps
`default_nettype none
module pso_top
   import pso_pkg::*;
#(
   parameter int unsigned DATA_PINS = PSO_DATA_PINS,
   parameter int unsigned TRI_PINS  = PSO_TRI_PINS
) (
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   // Parallel side
   input  wire logic [5:0]  parallel_data_in,
   input  wire logic        data_path_clock_enable,
   input  wire logic [3:0]  parallel_tristate_in,
   input  wire logic        tristate_path_clock_enable,
   input  wire logic        async_reset_in,
   input  wire logic        reverse_set_reset,
   // Cascade
   input  wire logic        cascade_carry_in_a,
   input  wire logic        cascade_carry_in_b,
   output logic             cascade_carry_out_a,
   output logic             cascade_carry_out_b,
   // Serial side
   output logic             serial_data_out,
   output logic             serial_tristate_out
);

   // Pin counts are fixed by the word layout
   if (DATA_PINS != PSO_DATA_PINS || TRI_PINS != PSO_TRI_PINS) begin : g_bad_pins
      $error("pso_top: pin counts must stay 6 and 4");
   end

   // Shared timing and configuration
   pso_tick_if tick ();

   // Configuration checker for width and rate pairs
   function automatic logic cfg_ok(input logic [31:0] v);
      logic       ddr;
      logic [3:0] dw;
      logic [1:0] tr;
      logic [2:0] tw;
      logic       d_ok;
      logic       t_ok;
      ddr = v[PSO_F_DDR];
      dw  = v[PSO_F_DW +: 4];
      tr  = v[PSO_F_TRATE +: 2];
      tw  = v[PSO_F_TW +: 3];
      if (ddr) begin
         d_ok = (dw == 4'h4) || (dw == 4'h6) || (dw == 4'h8) || (dw == 4'ha);
      end else begin
         d_ok = (dw >= 4'h2) && (dw <= 4'h8);
      end
      if (tr == PSO_TRI_DDR) begin
         // Setting_a 4 pins the data to DDR 4 or SDR 2
         t_ok = ((tw == 3'h2) || (tw == 3'h4))
              && (tw != 3'h4 || (ddr ? (dw == 4'h4) : (dw == 4'h2)));
      end else begin
         t_ok = ((tr == PSO_TRI_SDR) || (tr == PSO_TRI_BUF)) && (tw == 3'h1);
      end
      return d_ok && t_ok;
   endfunction

   // Bus state
   logic [10:0] cfg_reg;     // Rate, role and widths
   logic [10:0] cfg_next;
   logic        wr_pend_reg; // Write data phase pending
   logic        wr_cfg_reg;  // That write targets config
   logic [31:0] hrdata_reg;  // Read data, set in address phase
   logic        hready_reg;  // Always ready once out of reset

   // Address decode
   wire         addr_phase = hsel && hready && htrans[1];
   wire         word_size  = (hsize == 3'b010);
   wire         upper_zero = (haddr[31:8] == 24'h0);
   wire         hit_cfg    = upper_zero && (haddr[7:0] == PSO_CFG_ADDR);
   wire         hit_stat   = upper_zero && (haddr[7:0] == PSO_STAT_ADDR);
   // Illegal combinations are dropped, old setting kept
   wire         cfg_write  = wr_pend_reg && wr_cfg_reg && cfg_ok(hwdata);

   // Write lands this cycle, so a read right behind sees it
   assign cfg_next = cfg_write ? hwdata[10:0] : cfg_reg;

   // Read views
   wire  [31:0] cfg_view  = {21'h0, cfg_next};
   wire  [31:0] stat_view = {24'h0, tick.bit_idx, 2'b00, tick.fast_rst, tick.div_rst};
   wire  [31:0] rd_mux    = hit_cfg ? cfg_view : (hit_stat ? stat_view : 32'h0);

   // Address phase capture; unmapped reads give zero
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         wr_pend_reg <= 1'b0;
         wr_cfg_reg  <= 1'b0;
         hrdata_reg  <= 32'h0;
      end else if (addr_phase) begin
         wr_pend_reg <= hwrite && word_size;
         wr_cfg_reg  <= hit_cfg;
         hrdata_reg  <= hwrite ? 32'h0 : rd_mux;
      end else begin
         wr_pend_reg <= 1'b0;
      end
   end

   // Settings register, defaults on reset
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         cfg_reg    <= PSO_CFG_RESET[10:0];
         hready_reg <= 1'b0;
      end else begin
         cfg_reg    <= cfg_next;
         hready_reg <= 1'b1;
      end
   end

   // Zero wait states, always OKAY
   assign hreadyout = hready_reg;
   assign hrdata    = hrdata_reg;
   assign hresp     = 1'b0;

   // Settings onto the carrier
   wire is_slave = cfg_reg[PSO_F_SLAVE];
   assign tick.data_ddr   = cfg_reg[PSO_F_DDR];
   assign tick.data_width = cfg_reg[PSO_F_DW +: 4];
   assign tick.tri_rate   = pso_trate_t'(cfg_reg[PSO_F_TRATE +: 2]);
   assign tick.tri_width  = cfg_reg[PSO_F_TW +: 3];

   // Divider and reset re-timing
   pso_timing u_timing (
      .clk_sys        (clk_sys),
      .reset_n        (reset_n),
      .async_reset_in (async_reset_in),
      .tick           (tick)
   );

   // Tristate serial path
   pso_tri_ser u_tri (
      .clk_sys                    (clk_sys),
      .reset_n                    (reset_n),
      .parallel_tristate_in       (parallel_tristate_in),
      .tristate_path_clock_enable (tristate_path_clock_enable),
      .tick                       (tick),
      .serial_tristate_out        (serial_tristate_out)
   );

   // Data path state
   logic [5:0] pword_reg; // Captured parallel word
   logic       oq_reg;    // Serial data flop
   logic       carry_a_reg;
   logic       carry_b_reg;
   logic       clear;
   logic       cap;

   // Pin reset wins over every data flop at once
   assign clear = !reset_n || tick.hard_clear;
   // Capture only at the divided edge with enable high
   assign cap   = tick.div_tick && data_path_clock_enable;

   // Bit maps: master order and slave carry order
   logic [15:0] master_map;
   logic [15:0] slave_map;
   for (genvar i = 0; i < 16; i++) begin : g_map
      if (i < 6) begin : g_low
         assign master_map[i] = pword_reg[i];
         assign slave_map[i]  = 1'b0;
      end else if (i < 10) begin : g_ext
         // Bits past six come over the cascade
         assign master_map[i] = cascade_carry_in_a;
         assign slave_map[i]  = pword_reg[i - 6 + PSO_SLAVE_PIN];
      end else begin : g_none
         assign master_map[i] = 1'b0;
         assign slave_map[i]  = 1'b0;
      end
   end

   // Second carry is a look-ahead; this block reads only the first
   wire unused_carry = cascade_carry_in_b;

   // Parallel capture
   always_ff @(posedge clk_sys) begin
      if (clear || tick.div_rst) begin
         pword_reg <= 6'h0;
      end else if (cap) begin
         pword_reg <= parallel_data_in;
      end
   end

   // Serial output, one bit per cycle, held while disabled
   always_ff @(posedge clk_sys) begin
      if (clear || tick.fast_rst) begin
         oq_reg <= 1'b0;
      end else if (data_path_clock_enable) begin
         // Slave drives no pin of its own
         oq_reg <= is_slave ? 1'b0 : master_map[tick.bit_idx];
      end
   end

   // Slave presents next cycle's bit to the master
   always_ff @(posedge clk_sys) begin
      if (clear || tick.fast_rst) begin
         carry_a_reg <= 1'b0;
         carry_b_reg <= 1'b0;
      end else if (data_path_clock_enable) begin
         carry_a_reg <= is_slave && slave_map[tick.bit_idx_next];
         carry_b_reg <= is_slave && slave_map[4'(tick.bit_idx_next + 4'h1)];
      end
   end

   assign serial_data_out     = oq_reg;
   assign cascade_carry_out_a = carry_a_reg;
   assign cascade_carry_out_b = carry_b_reg;

   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   chk_capture_word: assert property (
      cap && !clear |=> pword_reg == $past(parallel_data_in))
      else $error("word not captured at boundary");

   chk_first_bit: assert property (
      !is_slave && data_path_clock_enable && !clear && !tick.fast_rst && tick.bit_idx == 4'h0
      |=> serial_data_out == $past(pword_reg[0]))
      else $error("first pin not sent first");

   chk_bit_order: assert property (
      !is_slave && data_path_clock_enable && !clear && !tick.fast_rst && tick.bit_idx == 4'h1
      |=> serial_data_out == $past(pword_reg[1]))
      else $error("second pin out of order");

   chk_data_hold: assert property (
      !data_path_clock_enable && !clear ##1 !clear |-> $stable(serial_data_out) && $stable(pword_reg))
      else $error("data path moved while disabled");

   chk_clear_low: assert property (
      tick.hard_clear |=> serial_data_out == 1'b0 && pword_reg == 6'h0 && cascade_carry_out_a == 1'b0)
      else $error("reset pin did not clear flops");

   chk_reset_sync: assert property (
      $fell(tick.hard_clear) |=> !tick.div_rst && tick.bit_idx == 4'h0 ##1 !tick.fast_rst)
      else $error("reset release not in step");

   chk_cfg_legal: assert property (
      cfg_ok(cfg_view))
      else $error("illegal configuration stored");

   chk_slave_carry: assert property (
      is_slave && data_path_clock_enable && !clear && !tick.fast_rst && tick.bit_idx_next == PSO_SLAVE_FIRST
      |=> cascade_carry_out_a == $past(pword_reg[PSO_SLAVE_PIN]))
      else $error("slave carry not third pin");

   chk_ddr_fast: assert property (
      tick.data_ddr && !tick.div_rst && tick.bit_idx[0] |-> !tick.fast_tick)
      else $error("fast clock not half rate in DDR");

   cov_ddr_word: cover property (cap && tick.data_ddr ##1 tick.bit_idx == 4'h0);
   cov_width_ten: cover property (!is_slave && tick.data_width == 4'ha && tick.bit_idx == 4'h9);
   cov_release: cover property ($fell(tick.hard_clear) ##2 !tick.fast_rst);
   cov_sdr_eight: cover property (!tick.data_ddr && tick.data_width == 4'h8 && cap);

endmodule
`default_nettype wire

// ==== logic/pso_tri_ser.sv ====
// Tristate control parallel-to-serial path
`timescale 1ns/1ps
`default_nettype none
module pso_tri_ser
   import pso_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       reset_n,
   input  wire logic [3:0] parallel_tristate_in,
   input  wire logic       tristate_path_clock_enable,
   pso_tick_if.user        tick,
   output logic            serial_tristate_out
);
   logic [3:0] tword_reg; // Captured tristate word
   logic       tq_reg;    // Serial tristate flop
   logic [6:0] tprod;
   logic [3:0] tidx;
   logic       clear;

   assign clear = !reset_n || tick.hard_clear;
   // Spread tristate bits evenly over the data word
   assign tprod = 7'(tick.bit_idx * tick.tri_width);
   assign tidx  = 4'(tprod / 7'(tick.data_width));

   // Capture on word boundary, hold while disabled
   always_ff @(posedge clk_sys) begin
      if (clear || tick.div_rst) begin
         tword_reg <= 4'h0;
      end else if (tick.div_tick && tristate_path_clock_enable) begin
         tword_reg <= parallel_tristate_in;
      end
   end

   // Serial stage: SDR width 1, DDR width 2 or 4
   always_ff @(posedge clk_sys) begin
      if (clear || tick.fast_rst) begin
         tq_reg <= 1'b0;
      end else if (tristate_path_clock_enable) begin
         tq_reg <= tword_reg[tidx[1:0]];
      end
   end

   // Buffer mode bypasses every flop
   assign serial_tristate_out = (tick.tri_rate == PSO_TRI_BUF) ? parallel_tristate_in[0] : tq_reg;

   chk_tri_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !tristate_path_clock_enable && !clear ##1 !clear |-> $stable(tq_reg)) else $error("tristate moved while disabled");
   chk_tri_buf: assert property (@(posedge clk_sys) disable iff (!reset_n)
      tick.tri_rate == PSO_TRI_BUF |-> serial_tristate_out == parallel_tristate_in[0]) else $error("buffer mode not passing");
   cov_tri_buf: cover property (@(posedge clk_sys) tick.tri_rate == PSO_TRI_BUF && parallel_tristate_in[0]);
endmodule
`default_nettype wire

// ==== pkg/pso_pkg.sv ====
// Shared constants and types for the output serializer
package pso_pkg;
   // Pin counts of the parallel side
   localparam int unsigned PSO_DATA_PINS = 6;
   localparam int unsigned PSO_TRI_PINS  = 4;
   // First word bit supplied by a cascaded slave
   localparam logic [3:0]  PSO_SLAVE_FIRST = 4'h6;
   // Slave pin that carries that bit (third data pin)
   localparam int unsigned PSO_SLAVE_PIN = 2;
   // Register byte offsets
   localparam logic [7:0]  PSO_CFG_ADDR  = 8'h00;
   localparam logic [7:0]  PSO_STAT_ADDR = 8'h04;
   // Configuration field positions
   localparam int unsigned PSO_F_DDR   = 0;
   localparam int unsigned PSO_F_SLAVE = 1;
   localparam int unsigned PSO_F_TRATE = 2;
   localparam int unsigned PSO_F_DW    = 4;
   localparam int unsigned PSO_F_TW    = 8;
   localparam int unsigned PSO_CFG_W   = 11;
   // After reset: data DDR, master, tristate DDR, width 4, setting_a 4
   localparam logic [31:0] PSO_CFG_RESET = 32'h0000_0449;
   // Tristate rate choices
   typedef enum logic [1:0] {
      PSO_TRI_BUF = 2'b00,
      PSO_TRI_SDR = 2'b01,
      PSO_TRI_DDR = 2'b10
   } pso_trate_t;
   // Reset release sequence
   typedef enum logic [1:0] {
      PSO_RS_HOLD = 2'b00,
      PSO_RS_DIV  = 2'b01,
      PSO_RS_RUN  = 2'b10
   } pso_rst_t;
endpackage

// ==== pkg/pso_tick_if.sv ====
// Timing, reset and configuration carrier between serializer modules
`timescale 1ns/1ps
`default_nettype none
interface pso_tick_if;
   import pso_pkg::*;
   logic       hard_clear;   // Reset pin high this cycle
   logic       div_rst;      // Divided-domain reset
   logic       fast_rst;     // Fast-domain reset
   logic       div_tick;     // Word boundary, parallel capture
   logic       fast_tick;    // Fast clock rising edge
   logic [3:0] bit_idx;      // Bit now being sent
   logic [3:0] bit_idx_next; // Bit sent next cycle
   logic       data_ddr;     // Data rate
   logic [3:0] data_width;   // Bits per word
   pso_trate_t tri_rate;     // Tristate rate
   logic [2:0] tri_width;    // Tristate bits per word
   modport gen (output hard_clear, div_rst, fast_rst, div_tick, fast_tick,
                bit_idx, bit_idx_next, input data_ddr, data_width);
   modport user (input hard_clear, div_rst, fast_rst, div_tick, fast_tick,
                 bit_idx, bit_idx_next, data_ddr, data_width, tri_rate, tri_width);
endinterface
`default_nettype wire

// ==== verif/pso_pad_model.sv ====
// Output buffer model that records the serial data and tristate streams
`timescale 1ns/1ps
`default_nettype none
module pso_pad_model (
   input  wire logic        clk_sys,
   input  wire logic        serial_data_out,
   input  wire logic        serial_tristate_out,
   output logic      [19:0] recent_bits,
   output logic      [19:0] recent_tri
);
   // One bit per clk_sys cycle, newest in bit 0; 20 bits hold two widest words
   always_ff @(posedge clk_sys) begin
      recent_bits <= {recent_bits[18:0], serial_data_out};
      recent_tri  <= {recent_tri[18:0], serial_tristate_out};
   end
endmodule
`default_nettype wire

// ==== verif/pso_top_tb.sv ====
// Self-checking bench: master and cascaded slave serializer on one bus
`timescale 1ns/1ps
`default_nettype none
module pso_top_tb;
   import pso_pkg::*;
   logic        clk_sys, reset_n, hsel_m, hsel_s, hwrite, hready, sel_s;
   logic        rdy_m, rdy_s, sdo_m, sto_m, carry_a, carry_b, resp_m;
   logic        data_path_clock_enable, tristate_path_clock_enable, async_reset_in;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, rdata_m, rdata_s, rd;
   logic [5:0]  pd_m, pd_s;
   logic [3:0]  parallel_tristate_in;
   logic [19:0] recent_bits, recent_tri;
   int          mismatches, n_tests;
   // Stream cases: DDR6, SDR3, SDR7, SDR8, DDR8, DDR10 (slave gets bit 1 set)
   logic [31:0] cfgs [6] = '{32'h0000_0161, 32'h0000_0134, 32'h0000_0174,
                             32'h0000_0184, 32'h0000_0181, 32'h0000_01a1};

   // Both slaves answer with zero wait, so one ready line serves
   assign hready = rdy_m & rdy_s;

   pso_top u_pso_top (
      .clk_sys, .reset_n, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
      .hsel(hsel_m), .hreadyout(rdy_m), .hrdata(rdata_m), .hresp(resp_m),
      .parallel_data_in(pd_m), .data_path_clock_enable, .parallel_tristate_in,
      .tristate_path_clock_enable, .async_reset_in, .reverse_set_reset(1'b0),
      .cascade_carry_in_a(carry_a), .cascade_carry_in_b(carry_b),
      .cascade_carry_out_a(), .cascade_carry_out_b(),
      .serial_data_out(sdo_m), .serial_tristate_out(sto_m));
   // Slave end feeding the master carries; its own serial outputs unused
   pso_top u_pso_top_slave (
      .clk_sys, .reset_n, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
      .hsel(hsel_s), .hreadyout(rdy_s), .hrdata(rdata_s), .hresp(),
      .parallel_data_in(pd_s), .data_path_clock_enable, .parallel_tristate_in,
      .tristate_path_clock_enable, .async_reset_in, .reverse_set_reset(1'b0),
      .cascade_carry_in_a(1'b0), .cascade_carry_in_b(1'b0),
      .cascade_carry_out_a(carry_a), .cascade_carry_out_b(carry_b),
      .serial_data_out(), .serial_tristate_out());
   pso_pad_model u_pso_pad_model (
      .clk_sys, .serial_data_out(sdo_m), .serial_tristate_out(sto_m), .recent_bits, .recent_tri);

   // Free-running 40 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   task check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task check_bit(input string what, input logic exp, input logic got);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %b, seen %b", what, exp, got);
      end
   endtask

   // True when the last 2*w bits are the word sent lowest bit first, any phase
   function automatic logic stream_ok(input logic [19:0] bits, input logic [9:0] word, input int w);
      logic hit, ok;
      hit = 1'b0;
      for (int r = 0; r < w; r++) begin
         ok = 1'b1;
         for (int t = 0; t < 2 * w; t++)
            if (bits[2 * w - 1 - t] !== word[(t + r) % w]) ok = 1'b0;
         hit = hit | ok;
      end
      return hit;
   endfunction

   // Ready judged at the rising edge; read data taken at that same edge
   task wait_ready;
      int n;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (hready !== 1'b1 && n < 100);
      if (hready !== 1'b1) begin
         mismatches++;
         $display("unexpected bus ready: expected 1, seen %b", hready);
      end
      rd = sel_s ? rdata_s : rdata_m;
   endtask

   // One single word transfer; read data left in rd
   task bus(input logic s, input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk_sys);
      sel_s = s;
      hsel_m <= ~s;
      hsel_s <= s;
      haddr <= {24'h000000, a};
      htrans <= 2'b10;
      hwrite <= wr;
      hsize <= 3'b010;
      wait_ready();
      hsel_m <= 1'b0;
      hsel_s <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_ready();
   endtask

   // Configure both ends, reset them together, let the stream settle
   task run_cfg(input logic [31:0] cfg);
      bus(1'b0, 1'b1, PSO_CFG_ADDR, cfg);
      bus(1'b1, 1'b1, PSO_CFG_ADDR, cfg | 32'h0000_0002);
      @(posedge clk_sys);
      pd_m <= 6'h0b;
      pd_s <= 6'h03; // Unused slave pins high to expose misuse
      async_reset_in <= 1'b1;
      repeat (10) @(posedge clk_sys);
      async_reset_in <= 1'b0;
      repeat (50) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask

   task t_regs;
      logic [31:0] bad [3] = '{32'h0000_0131, 32'h0000_0245, 32'h0000_0469};
      bus(1'b0, 1'b0, PSO_CFG_ADDR, 32'h0);
      check_word("config reset", 32'h0000_0449, rd);
      bus(1'b0, 1'b1, 8'h08, 32'hffff_ffff);
      bus(1'b0, 1'b0, 8'h08, 32'h0);
      check_word("unmapped read", 32'h0, rd);
      // Illegal rate and width pairs are dropped
      foreach (bad[i]) begin
         bus(1'b0, 1'b1, PSO_CFG_ADDR, bad[i]);
         bus(1'b0, 1'b0, PSO_CFG_ADDR, 32'h0);
         check_word("config kept", 32'h0000_0449, rd);
      end
      // Refused settings are dropped silently, the bus still answers OKAY
      check_bit("bus response", 1'b0, resp_m);
      bus(1'b0, 1'b1, PSO_CFG_ADDR, 32'h0000_0134);
      bus(1'b0, 1'b0, PSO_CFG_ADDR, 32'h0);
      check_word("config sdr3", 32'h0000_0134, rd);
      $display("test registers done");
   endtask

   task t_stream;
      foreach (cfgs[i]) begin
         run_cfg(cfgs[i]);
         check_bit("stream order", 1'b1, stream_ok(recent_bits, 10'h00b, int'(cfgs[i][7:4])));
      end
      $display("test stream done");
   endtask

   // Drop one enable for nine cycles; the chosen output must stand still
   task hold_check(input logic on_tri);
      logic held;
      @(posedge clk_sys);
      if (on_tri) tristate_path_clock_enable <= 1'b0;
      else data_path_clock_enable <= 1'b0;
      @(negedge clk_sys);
      held = on_tri ? sto_m : sdo_m;
      repeat (8) begin
         @(negedge clk_sys);
         check_bit("held output", held, on_tri ? sto_m : sdo_m);
      end
      @(posedge clk_sys);
      tristate_path_clock_enable <= 1'b1;
      data_path_clock_enable <= 1'b1;
   endtask

   task t_hold;
      run_cfg(32'h0000_0161);
      hold_check(1'b0);
      repeat (40) @(posedge clk_sys);
      @(negedge clk_sys);
      check_bit("resumed stream", 1'b1, stream_ok(recent_bits, 10'h00b, 6));
      $display("test hold done");
   endtask

   task t_tri;
      run_cfg(32'h0000_0449);
      check_word("tristate ones w4", 32'd1, 32'($countones(recent_tri[3:0])));
      run_cfg(32'h0000_0249);
      check_word("tristate ones w2", 32'd2, 32'($countones(recent_tri[3:0])));
      hold_check(1'b1);
      // Pass-through: a flop would still show the old bit here
      run_cfg(32'h0000_0161);
      @(posedge clk_sys);
      parallel_tristate_in <= 4'b1110;
      @(negedge clk_sys);
      check_bit("buffer low", 1'b0, sto_m);
      @(posedge clk_sys);
      parallel_tristate_in <= 4'b0001;
      @(negedge clk_sys);
      check_bit("buffer high", 1'b1, sto_m);
      $display("test tristate done");
   endtask

   task t_reset;
      run_cfg(32'h0000_0181);
      @(posedge clk_sys);
      async_reset_in <= 1'b1;
      @(posedge clk_sys);
      repeat (3) begin
         @(negedge clk_sys);
         check_word("cleared outputs", 32'h0, {29'h0, sdo_m, carry_a, carry_b});
      end
      bus(1'b0, 1'b0, PSO_STAT_ADDR, 32'h0);
      check_word("status in reset", 32'h3, rd & 32'h3);
      @(posedge clk_sys);
      async_reset_in <= 1'b0;
      repeat (40) @(posedge clk_sys);
      bus(1'b0, 1'b0, PSO_STAT_ADDR, 32'h0);
      check_word("status released", 32'h0, rd & 32'h3);
      @(negedge clk_sys);
      check_bit("stream after reset", 1'b1, stream_ok(recent_bits, 10'h00b, 8));
      $display("test reset done");
   endtask

   task end_of_test;
      $display("checks %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // Main sequence
   initial begin
      reset_n = 1'b0;
      {hsel_m, hsel_s, hwrite, sel_s, async_reset_in} = 5'h00;
      {data_path_clock_enable, tristate_path_clock_enable} = 2'b11;
      htrans = 2'b00;
      hsize = 3'b010;
      haddr = 32'h0;
      hwdata = 32'h0;
      pd_m = 6'h00;
      pd_s = 6'h00;
      parallel_tristate_in = 4'b0001;
      mismatches = 0;
      n_tests = 0;
      repeat (12) @(posedge clk_sys);
      reset_n <= 1'b1;
      t_regs();
      t_stream();
      t_hold();
      t_tri();
      t_reset();
      end_of_test();
   end

   // Hang guard, well beyond the roughly 900 cycles the tests need
   initial begin
      repeat (20000) @(posedge clk_sys);
      mismatches++;
      $display("watchdog expired");
      end_of_test();
   end
endmodule
`default_nettype wire
